// ==== include/hslf_pkg.sv ====
package hslf_pkg;
    localparam int NUM_THREADS   = 8;
    localparam int NUM_STACKS    = 4;
    localparam int STK_IDX_W     = 2;
    localparam int OPND_W        = 3;
    localparam int OPND_POP_BIT  = 2;
    localparam int DATA_W        = 32;
    localparam int STK_ADDR_W    = 2;
    localparam int THREAD_W      = 3;
    localparam bit PROT_PUSH_DEF = 1'b0;
    localparam bit PROT_POP_DEF  = 1'b1;
endpackage

// ==== src/hslf_level_ctl.sv ====
`timescale 1ns/1ps
module hslf_level_ctl
    import hslf_pkg::*;
#(
    parameter int AW        = STK_ADDR_W,
    parameter bit PROT_PUSH = PROT_PUSH_DEF,
    parameter bit PROT_POP  = PROT_POP_DEF
) (
    input  wire logic [AW:0] levelIn,
    input  wire logic        popReq,
    input  wire logic        pushReq,
    output logic      [AW:0] levelOut,
    output logic             writeEn,
    output logic      [AW-1:0] writeAddr,
    output logic             pushErr,
    output logic             popErr
);
    localparam logic [AW:0] LVL_FULL = (AW+1)'(1 << AW);
    localparam logic [AW:0] LVL_ONE  = (AW+1)'(1);

    logic isEmpty;
    logic isFull;
    logic doPop;
    logic doPush;
    logic [AW:0] afterPop;

    assign isEmpty  = (levelIn == '0);                        // RL1
    assign isFull   = (levelIn == LVL_FULL);                  // RL1
    // pop ahead of push: a full stack that pops first has room
    assign popErr   = popReq & isEmpty;                       // RL6
    assign pushErr  = pushReq & isFull & ~popReq;             // RL5 RL9
    assign doPop    = popReq & ~(popErr & PROT_POP);          // RL12 RL10
    assign doPush   = pushReq & ~(pushErr & PROT_PUSH);       // RL11
    assign afterPop = doPop ? levelIn - LVL_ONE : levelIn;
    assign levelOut = doPush ? afterPop + LVL_ONE : afterPop; // RL8
    assign writeEn  = doPush;
    // low bits only: a full stack's last entry sits at address 0
    assign writeAddr = levelOut[AW-1:0];                      // RL4
endmodule

// ==== src/hslf_top_read.sv ====
`timescale 1ns/1ps
module hslf_top_read
    import hslf_pkg::*;
#(
    parameter int DW = DATA_W,
    parameter int AW = STK_ADDR_W
) (
    input  wire logic [(1<<AW)*DW-1:0] memFlat,
    input  wire logic [AW:0]           level,
    output logic      [DW-1:0]         topData,
    output logic                       topValid
);
    logic [AW-1:0] rdAddr;
    assign rdAddr   = level[AW-1:0];                          // RL3
    assign topData  = memFlat[rdAddr*DW +: DW];               // RL15
    // empty still shows the stale word; validity says ignore it
    assign topValid = (level != '0);                          // RL7
endmodule

// ==== src/hybrid_stack_register_lifo.sv ====
`timescale 1ns/1ps
// Operation
// RL1: one pointer doubles as level; full/empty
// RL2: first push from empty writes address one
// RL3: level has extra bit; low bits address
// RL4: filling push lands at address zero
// RL5: push when full is an error
// RL6: pop when empty is an error
// RL7: empty shows word, marked invalid
// RL8: pop and push replaces top, level kept
// RL9: pop and push when full: no error
// RL10: pop and push empty: pop error only
// RL11: overflow protection drops push entirely
// RL12: underflow protection stops level wrapping
// RL13: push and pop protection separate parameters
// RL14: every stack error reported out
// RL15: only top entries reach the ALU
// RL16: read pop bit zero keeps, one pops
// RL17: write pop bit zero pushes, one replaces
// RL18: same stack pop bits are ORed
// RL19: operand is pop bit plus index
// RL20: four isolated stacks per thread
// RL21: clear empties selected thread's stacks
// RL22: suppressed instruction touches no stack
module hybrid_stack_register_lifo
    import hslf_pkg::*;
#(
    parameter int NT        = NUM_THREADS,
    parameter int DW        = DATA_W,
    parameter int AW        = STK_ADDR_W,
    parameter bit PROT_PUSH = PROT_PUSH_DEF,                  // RL13
    parameter bit PROT_POP  = PROT_POP_DEF                    // RL13
) (
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    input  wire logic [$clog2(NT)-1:0] rdThread,
    input  wire logic [OPND_W-1:0]   opndA,
    input  wire logic [OPND_W-1:0]   opndB,
    input  wire logic                rdEn,
    input  wire logic                wrEn,
    input  wire logic                execOk,
    input  wire logic [DW-1:0]       wrData,
    input  wire logic                clrReq,
    input  wire logic [$clog2(NT)-1:0] clrThread,
    input  wire logic [$clog2(NT)-1:0] outThread,
    output logic      [DW-1:0]       dataA,
    output logic                     validA,
    output logic      [DW-1:0]       dataB,
    output logic                     validB,
    output logic      [NUM_STACKS-1:0] pushErrOut,
    output logic      [NUM_STACKS-1:0] popErrOut,
    output logic      [$clog2(NT)-1:0] errThread
);
    localparam int TW    = $clog2(NT);
    localparam int DEPTH = 1 << AW;
    localparam int NS    = NUM_STACKS;

    typedef enum logic [1:0] {
        HSLF_RUN = 2'b01,
        HSLF_CLR = 2'b10
    } hslf_mode_e;

    logic [AW:0]   levelQ [NT][NS];
    logic [DW-1:0] memQ   [NT][NS][DEPTH];
    logic [DW-1:0] dataAQ, dataBQ;
    logic          validAQ, validBQ;
    logic [NS-1:0] pushErrQ, popErrQ;
    logic [TW-1:0] errThreadQ;
    hslf_mode_e    modeW;

    logic [STK_IDX_W-1:0] idxA, idxB;
    logic                 popA, popB;
    logic                 active;
    logic [NS-1:0]        popReq, pushReq, rdPop, wrPop;
    logic [TW-1:0]        nextThr;
    logic [AW:0]          lvlNext [NS];
    logic [NS-1:0]        wEn, pErr, oErr;
    logic [AW-1:0]        wAddr [NS];
    logic [DW-1:0]        topD [NS];
    logic [NS-1:0]        topV;

    function automatic logic [NS-1:0] sel_onehot(
        input logic [STK_IDX_W-1:0] idx);
        sel_onehot = NS'(1) << idx;
    endfunction

    assign idxA   = opndA[STK_IDX_W-1:0];                     // RL19
    assign idxB   = opndB[STK_IDX_W-1:0];                     // RL19
    assign popA   = opndA[OPND_POP_BIT];
    assign popB   = opndB[OPND_POP_BIT];
    assign active = execOk;                                   // RL22
    assign modeW  = clrReq ? HSLF_CLR : HSLF_RUN;

    // read and write pops ORed per stack so one stack never pops twice
    assign rdPop  = {NS{active & rdEn}} &
                    (({NS{popA}} & sel_onehot(idxA)) |
                     ({NS{popB}} & sel_onehot(idxB)));        // RL16
    // a destination pop bit turns the write into pop and push
    assign wrPop  = {NS{active & wrEn & popA}} & sel_onehot(idxA); // RL17
    assign popReq = rdPop | wrPop;                            // RL18
    // destination is A; its pop bit makes the write a replace
    assign pushReq = {NS{active & wrEn}} & sel_onehot(idxA);  // RL17

    genvar s;
    generate
        for (s = 0; s < NS; s++) begin : g_stk
            logic [DEPTH*DW-1:0] flat;
            for (genvar e = 0; e < DEPTH; e++) begin : g_flat
                assign flat[e*DW +: DW] = memQ[rdThread][s][e];
            end
            hslf_level_ctl #(
                .AW        (AW),
                .PROT_PUSH (PROT_PUSH),
                .PROT_POP  (PROT_POP)
            ) u_lvl (
                .levelIn   (levelQ[rdThread][s]),
                .popReq    (popReq[s]),
                .pushReq   (pushReq[s]),
                .levelOut  (lvlNext[s]),
                .writeEn   (wEn[s]),
                .writeAddr (wAddr[s]),
                .pushErr   (oErr[s]),
                .popErr    (pErr[s])
            );
            hslf_top_read #(
                .DW (DW),
                .AW (AW)
            ) u_rd (
                .memFlat  (flat),
                .level    (levelQ[rdThread][s]),
                .topData  (topD[s]),
                .topValid (topV[s])
            );
        end
    endgenerate

    // one thread per cycle, plus clrThread on a clear; others keep their stacks untouched
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int t = 0; t < NT; t++) begin
                for (int k = 0; k < NS; k++) begin
                    levelQ[t][k] <= '0;
                end
            end
        end else begin
            for (int k = 0; k < NS; k++) begin
                levelQ[rdThread][k] <= lvlNext[k];            // RL20
            end
            case (modeW)
                HSLF_CLR: begin
                    for (int k = 0; k < NS; k++) begin
                        levelQ[clrThread][k] <= '0;           // RL21
                    end
                end
                HSLF_RUN: begin
                end
                default: begin
                end
            endcase
        end
    end

    // data storage needs no reset; level alone marks validity
    always_ff @(posedge sys_clk) begin
        for (int k = 0; k < NS; k++) begin
            if (wEn[k]) begin
                memQ[rdThread][k][wAddr[k]] <= wrData;        // RL2
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dataAQ     <= '0;
            dataBQ     <= '0;
            validAQ    <= 1'b0;
            validBQ    <= 1'b0;
            pushErrQ   <= '0;
            popErrQ    <= '0;
            errThreadQ <= '0;
        end else begin
            dataAQ     <= topD[idxA];                         // RL15
            dataBQ     <= topD[idxB];                         // RL15
            validAQ    <= topV[idxA];                         // RL7
            validBQ    <= topV[idxB];                         // RL7
            pushErrQ   <= oErr;                               // RL14
            popErrQ    <= pErr;                               // RL14
            errThreadQ <= rdThread;
        end
    end

    assign dataA      = dataAQ;
    assign dataB      = dataBQ;
    assign validA     = validAQ;
    assign validB     = validBQ;
    assign pushErrOut = pushErrQ;
    assign popErrOut  = popErrQ;
    assign errThread  = errThreadQ;

    localparam logic [AW:0] FULL_L = (AW+1)'(DEPTH);

    property p_full_push_err;
        @(posedge sys_clk) disable iff (!rst_n)
        (active && wrEn && !clrReq && levelQ[rdThread][idxA] == FULL_L
         && !popReq[idxA])
        |=> pushErrOut[$past(idxA)];
    endproperty
    a_full_push_err: assert property (p_full_push_err) // RL5
        else $error("push on full stack not flagged");

    property p_empty_pop_err;
        @(posedge sys_clk) disable iff (!rst_n)
        (active && rdEn && popA && levelQ[rdThread][idxA] == '0)
        |=> popErrOut[$past(idxA)];
    endproperty
    a_empty_pop_err: assert property (p_empty_pop_err) // RL6
        else $error("pop on empty stack not flagged");

    property p_popush_full_ok;
        @(posedge sys_clk) disable iff (!rst_n)
        (active && rdEn && wrEn && popA &&
         levelQ[rdThread][idxA] == FULL_L)
        |=> !pushErrOut[$past(idxA)];
    endproperty
    a_popush_full_ok: assert property (p_popush_full_ok) // RL9
        else $error("pop and push on full raised push error");

    property p_popush_level;
        @(posedge sys_clk) disable iff (!rst_n)
        (active && rdEn && wrEn && popA && !clrReq &&
         levelQ[rdThread][idxA] != '0)
        |=> levelQ[$past(rdThread)][$past(idxA)]
            == $past(levelQ[rdThread][idxA]);
    endproperty
    a_popush_level: assert property (p_popush_level) // RL8
        else $error("pop and push changed level");

    property p_no_wrap;
        @(posedge sys_clk) disable iff (!rst_n)
        (PROT_POP && active && rdEn && popA && !wrEn &&
         levelQ[rdThread][idxA] == '0)
        |=> levelQ[$past(rdThread)][$past(idxA)] == '0;
    endproperty
    a_no_wrap: assert property (p_no_wrap) // RL12
        else $error("empty pop wrapped the level");

    property p_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        clrReq |=> levelQ[$past(clrThread)][0] == '0 &&
                   levelQ[$past(clrThread)][NS-1] == '0;
    endproperty
    a_clear: assert property (p_clear) // RL21
        else $error("clear left a stack non-empty");

    property p_suppress;
        @(posedge sys_clk) disable iff (!rst_n)
        (!execOk && !clrReq) |=> levelQ[$past(rdThread)][0]
                                 == $past(levelQ[rdThread][0]);
    endproperty
    a_suppress: assert property (p_suppress) // RL22
        else $error("suppressed instruction moved a stack");

    property p_valid_tracks;
        @(posedge sys_clk) disable iff (!rst_n)
        ##1 validA == ($past(levelQ[rdThread][idxA]) != '0);
    endproperty
    a_valid_tracks: assert property (p_valid_tracks) // RL7
        else $error("operand valid does not match level");

    // helper: a neighbour thread that this cycle must leave alone
    assign nextThr = rdThread + TW'(1);

    property p_first_push_addr;
        @(posedge sys_clk) disable iff (!rst_n)
        (active && wrEn && !popReq[idxA] &&
         levelQ[rdThread][idxA] == '0)
        |-> wEn[idxA] && wAddr[idxA] == AW'(1);
    endproperty
    a_first_push_addr: assert property (p_first_push_addr) // RL2
        else $error("first push from empty missed address one");

    property p_fill_addr;
        @(posedge sys_clk) disable iff (!rst_n)
        (active && wrEn && !popReq[idxA] &&
         levelQ[rdThread][idxA] == FULL_L - 1'b1)
        |-> wEn[idxA] && wAddr[idxA] == '0;
    endproperty
    a_fill_addr: assert property (p_fill_addr) // RL4
        else $error("filling push missed address zero");

    property p_full_push_keep;
        @(posedge sys_clk) disable iff (!rst_n)
        (PROT_PUSH && active && wrEn && !clrReq && !popReq[idxA] &&
         levelQ[rdThread][idxA] == FULL_L)
        |-> !wEn[idxA] ##1
            levelQ[$past(rdThread)][$past(idxA)] == FULL_L;
    endproperty
    a_full_push_keep: assert property (p_full_push_keep) // RL11
        else $error("protected full push changed the stack");

    property p_popush_empty;
        @(posedge sys_clk) disable iff (!rst_n)
        (PROT_POP && active && wrEn && popReq[idxA] && !clrReq &&
         levelQ[rdThread][idxA] == '0)
        |=> levelQ[$past(rdThread)][$past(idxA)] == (AW+1)'(1) &&
            !pushErrOut[$past(idxA)];
    endproperty
    a_popush_empty: assert property (p_popush_empty) // RL10
        else $error("pop and push on empty was not one push");

    property p_err_thread;
        @(posedge sys_clk) disable iff (!rst_n)
        (pErr != '0 || oErr != '0)
        |=> errThread == $past(rdThread) &&
            (popErrOut | pushErrOut) != '0;
    endproperty
    a_err_thread: assert property (p_err_thread) // RL14
        else $error("stack error not reported with its thread");

    property p_read_keep;
        @(posedge sys_clk) disable iff (!rst_n)
        (active && rdEn && !wrEn && !popA && !clrReq &&
         !(popB && idxB == idxA))
        |=> levelQ[$past(rdThread)][$past(idxA)]
            == $past(levelQ[rdThread][idxA]);
    endproperty
    a_read_keep: assert property (p_read_keep) // RL16
        else $error("register type read moved the level");

    property p_single_pop;
        @(posedge sys_clk) disable iff (!rst_n)
        (active && rdEn && !wrEn && popA && popB && idxA == idxB &&
         !clrReq && levelQ[rdThread][idxA] != '0)
        |=> levelQ[$past(rdThread)][$past(idxA)]
            == $past(levelQ[rdThread][idxA]) - 1'b1;
    endproperty
    a_single_pop: assert property (p_single_pop) // RL18
        else $error("two pop bits on one stack did not pop once");

    // only valid entries are compared; unwritten words stay unknown
    property p_top_data;
        @(posedge sys_clk) disable iff (!rst_n)
        (levelQ[rdThread][idxA] != '0)
        |=> dataA ==
            $past(memQ[rdThread][idxA][levelQ[rdThread][idxA][AW-1:0]]);
    endproperty
    a_top_data: assert property (p_top_data) // RL15
        else $error("operand A is not the top entry");

    property p_isolated;
        @(posedge sys_clk) disable iff (!rst_n)
        (!(clrReq && clrThread == nextThr))
        |=> levelQ[$past(nextThr)][0] == $past(levelQ[nextThr][0]);
    endproperty
    a_isolated: assert property (p_isolated) // RL20
        else $error("a stack of another thread moved");

    property p_level_bound;
        @(posedge sys_clk) disable iff (!rst_n)
        (PROT_PUSH && PROT_POP) |-> levelQ[rdThread][idxA] <= FULL_L;
    endproperty
    a_level_bound: assert property (p_level_bound) // RL3
        else $error("protected level left its range");
endmodule

// ==== sim/hslf_pipe_model.sv ====
`timescale 1ns/1ps
module hslf_pipe_model
    import hslf_pkg::*;
(
    input  wire logic                sys_clk,
    output logic      [THREAD_W-1:0] rdThread,
    output logic      [OPND_W-1:0]   opndA,
    output logic      [OPND_W-1:0]   opndB,
    output logic                     rdEn,
    output logic                     wrEn,
    output logic                     execOk,
    output logic      [DATA_W-1:0]   wrData,
    output logic                     clrReq,
    output logic      [THREAD_W-1:0] clrThread
);
    // idle from time zero, so nothing reaches the stacks early
    initial begin
        {rdThread, opndA, opndB, rdEn, wrEn, execOk} = '0;
        {wrData, clrReq, clrThread} = '0;
    end

    // one instruction per cycle, driven 1 ns after the edge
    task automatic issue(input logic [THREAD_W-1:0] thr,
                         input logic rd, wr, ex,
                         input logic [OPND_W-1:0] a, b,
                         input logic [DATA_W-1:0] d,
                         input logic clr);
        rdThread = thr;
        opndA = a;
        opndB = b;
        rdEn = rd;
        wrEn = wr;
        execOk = ex;
        wrData = d;
        clrReq = clr;
        clrThread = thr;
        @(posedge sys_clk);
        #1;
    endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import hslf_pkg::*;
    logic                sys_clk;
    logic                rst_n;
    logic [THREAD_W-1:0] rdThread;
    logic [THREAD_W-1:0] clrThread;
    logic [THREAD_W-1:0] errThread;
    logic [THREAD_W-1:0] thr;
    logic [OPND_W-1:0]   opndA;
    logic [OPND_W-1:0]   opndB;
    logic                rdEn;
    logic                wrEn;
    logic                execOk;
    logic                clrReq;
    logic                validA;
    logic                validB;
    logic [DATA_W-1:0]   wrData;
    logic [DATA_W-1:0]   dataA;
    logic [DATA_W-1:0]   dataB;
    logic [3:0]          pushErrOut;
    logic [3:0]          popErrOut;
    int                  nErrors;
    int                  comparisons;

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // both protections on, so dropped pushes and clamped pops show
    hybrid_stack_register_lifo #(.PROT_PUSH(1'b1), .PROT_POP(1'b1)) i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .rdThread(rdThread),
        .opndA(opndA), .opndB(opndB), .rdEn(rdEn), .wrEn(wrEn),
        .execOk(execOk), .wrData(wrData), .clrReq(clrReq),
        .clrThread(clrThread), .outThread(3'h0), .dataA(dataA),
        .validA(validA), .dataB(dataB), .validB(validB),
        .pushErrOut(pushErrOut), .popErrOut(popErrOut),
        .errThread(errThread));

    hslf_pipe_model i_pipe (
        .sys_clk(sys_clk), .rdThread(rdThread), .opndA(opndA),
        .opndB(opndB), .rdEn(rdEn), .wrEn(wrEn), .execOk(execOk),
        .wrData(wrData), .clrReq(clrReq), .clrThread(clrThread));

    task automatic summarize();
        if (nErrors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            nErrors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic op(input logic rd, wr, ex, input logic [2:0] a, b,
                      input logic [31:0] d, input logic [3:0] ePush, ePop);
        i_pipe.issue(thr, rd, wr, ex, a, b, d, 1'b0);
        chk("push error", {28'h0, pushErrOut}, {28'h0, ePush});
        chk("pop error", {28'h0, popErrOut}, {28'h0, ePop});
        if (|(ePush | ePop)) chk("error thread", errThread, thr);
    endtask

    // empty stack data is compared only where known
    task automatic rd(input logic [2:0] a, input logic [31:0] eData,
                      input logic eValid, input logic [3:0] ePop,
                      input logic known);
        op(1'b1, 1'b0, 1'b1, a, a, 32'h0, 4'h0, ePop);
        chk("valid A", validA, eValid);
        chk("valid B", validB, eValid);
        if (known) chk("top A", dataA, eData);
        if (known) chk("top B", dataB, eData);
    endtask

    initial begin
        #100us;
        nErrors++;
        summarize();
    end

    initial begin
        nErrors = 0;
        comparisons = 0;
        thr = 3'h2;
        rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        rd(3'b000, 32'h0, 1'b0, 4'h0, 1'b0);
        for (int i = 1; i <= 4; i++)
            op(0, 1, 1, 3'b000, 3'b000, 32'hA0 + i, 4'h0, 4'h0);
        op(0, 1, 1, 3'b000, 3'b000, 32'hBAD, 4'h1, 4'h0);
        rd(3'b000, 32'hA4, 1'b1, 4'h0, 1'b1);
        rd(3'b000, 32'hA4, 1'b1, 4'h0, 1'b1);
        op(0, 1, 1, 3'b100, 3'b000, 32'hC0, 4'h0, 4'h0);
        rd(3'b100, 32'hC0, 1'b1, 4'h0, 1'b1);
        rd(3'b100, 32'hA3, 1'b1, 4'h0, 1'b1);
        rd(3'b100, 32'hA2, 1'b1, 4'h0, 1'b1);
        rd(3'b100, 32'hA1, 1'b1, 4'h0, 1'b1);
        rd(3'b000, 32'hC0, 1'b0, 4'h0, 1'b1);
        rd(3'b100, 32'hC0, 1'b0, 4'h1, 1'b1);
        op(0, 1, 1, 3'b000, 3'b000, 32'hD0, 4'h0, 4'h0);
        rd(3'b100, 32'hD0, 1'b1, 4'h0, 1'b1);
        rd(3'b000, 32'hC0, 1'b0, 4'h0, 1'b1);
        op(0, 1, 1, 3'b101, 3'b000, 32'hE0, 4'h0, 4'h2);
        rd(3'b101, 32'hE0, 1'b1, 4'h0, 1'b1);
        rd(3'b001, 32'h0, 1'b0, 4'h0, 1'b0);
        op(0, 1, 1, 3'b010, 3'b000, 32'hF1, 4'h0, 4'h0);
        op(0, 1, 1, 3'b010, 3'b000, 32'hF2, 4'h0, 4'h0);
        op(1, 1, 1, 3'b110, 3'b110, 32'hF3, 4'h0, 4'h0);
        rd(3'b110, 32'hF3, 1'b1, 4'h0, 1'b1);
        op(1, 1, 0, 3'b110, 3'b110, 32'h55, 4'h0, 4'h0);
        op(0, 1, 0, 3'b011, 3'b000, 32'h55, 4'h0, 4'h0);
        rd(3'b010, 32'hF1, 1'b1, 4'h0, 1'b1);
        rd(3'b011, 32'h0, 1'b0, 4'h0, 1'b0);
        thr = 3'h5;
        rd(3'b010, 32'h0, 1'b0, 4'h0, 1'b0);
        thr = 3'h2;
        i_pipe.issue(thr, 1'b0, 1'b0, 1'b0, 3'b0, 3'b0, 32'h0, 1'b1);
        rd(3'b010, 32'h0, 1'b0, 4'h0, 1'b0);
        summarize();
    end
endmodule
